// ===== pkg/ddc_pkg.sv
package ddc_pkg;
    // DRAM width option
    localparam logic [1:0] WID_X32 = 2'h0;
    localparam logic [1:0] WID_X16 = 2'h1;
    localparam logic [1:0] WID_X8 = 2'h2;
    localparam int ADDR_W = 13;
    localparam int BANKS = 4;
    // Auto-precharge bit position per width
    localparam int AP_BIT_X32 = 8;
    localparam int AP_BIT_X16X8 = 10;
    // Mode register fields
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam int MR_CL_LSB = 4;
    localparam int MR_DLL_BIT = 8;
    localparam logic [1:0] BA_MR = 2'h0;
    localparam logic [1:0] BA_EMR = 2'h1;
    // Command encodings {csN, rasN, casN, weN}
    localparam logic [3:0] CMD_DESEL = 4'hF;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_MRS = 4'h0;
    // Timing at 50 MHz
    localparam int CLK_MHZ = 50;
    localparam int T_WARM_US = 200;
    localparam int WARM_CYC = T_WARM_US * CLK_MHZ;
    localparam int T_RP_NS = 20;
    localparam int RP_CYC = (T_RP_NS * CLK_MHZ + 999) / 1000;
    localparam int T_MRD_NS = 15;
    localparam int MRD_CYC = (T_MRD_NS * CLK_MHZ + 999) / 1000;
    localparam int T_RFC_NS = 80;
    localparam int RFC_CYC = (T_RFC_NS * CLK_MHZ + 999) / 1000;
    localparam int DLL_CYC = 200;
    localparam int T_SNR_NS = 80;
    localparam int SNR_CYC = (T_SNR_NS * CLK_MHZ + 999) / 1000;
    localparam int T_XSRD_CYC = 200;
    localparam int T_WR_NS = 15;
    localparam int WR_CYC = (T_WR_NS * CLK_MHZ + 999) / 1000;
    localparam int REF_COUNT = 2;
    localparam int CNT_W = 16;
    // Avalon register offsets (word index = byte address / 4)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_MODE = 4'h1;
    localparam logic [3:0] REG_EMODE = 4'h2;
    localparam logic [3:0] REG_CMD = 4'h3;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam logic [31:0] RST_MODE = 32'h0000_0032;
    localparam logic [31:0] RST_EMODE = 32'h0000_0000;

    typedef enum logic [11:0] {
        ST_OFF = 12'h001, ST_WARM = 12'h002, ST_PALL1 = 12'h004,
        ST_EMRS = 12'h008, ST_MRS1 = 12'h010, ST_PALL2 = 12'h020,
        ST_AREF = 12'h040, ST_MRS2 = 12'h080, ST_DLLW = 12'h100,
        ST_READY = 12'h200, ST_PDN = 12'h400, ST_SREF = 12'h800
    } ddc_state_e;

    typedef struct packed {
        logic cke;
        logic [3:0] cmd;
        logic [1:0] ba;
        logic [12:0] addr;
    } ddc_pins_s;

    typedef struct packed {
        logic waitReq;
        logic rdValid;
        logic [31:0] rdData;
    } ddc_bus_s;
endpackage : ddc_pkg

// ===== hdl/ddc_ctrl.sv
// The Avalon-MM interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module ddc_ctrl #(
    parameter int WARM_CYCLES = ddc_pkg::WARM_CYC,
    parameter logic [1:0] WIDTH_SEL = ddc_pkg::WID_X16
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [3:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    input wire logic vrefStable,
    output logic dramCke,
    output logic dramCsN,
    output logic dramRasN,
    output logic dramCasN,
    output logic dramWeN,
    output logic [1:0] dramBa,
    output logic [12:0] dramAddr,
    output logic initDone
);
    typedef struct packed {
        ddc_pkg::ddc_state_e st;
        logic [ddc_pkg::CNT_W-1:0] cnt;
        logic [ddc_pkg::CNT_W-1:0] guard;
        logic [ddc_pkg::CNT_W-1:0] rdGuard;
        logic [1:0] refs;
        ddc_pkg::ddc_pins_s pins;
        ddc_pkg::ddc_bus_s bus;
        logic [12:0] modeVal;
        logic [12:0] emodeVal;
        logic [3:0] bankOpen;
        logic reqPdn;
        logic reqSref;
        logic cmdPend;
        logic [31:0] cmdWord;
        logic done;
    } ddc_state_s;

    ddc_state_s cur_ff;
    ddc_state_s nxt_cur;

    logic [3:0] cmdOp;
    logic [1:0] cmdBa;
    logic [12:0] cmdArg;
    logic cmdAp;
    logic busy;

    function automatic logic [12:0] apMask(input logic [1:0] w);
        logic [12:0] m;
        m = 13'h0000;
        if (w == ddc_pkg::WID_X32) begin
            m[ddc_pkg::AP_BIT_X32] = 1'b1;
        end else begin
            m[ddc_pkg::AP_BIT_X16X8] = 1'b1;
        end
        return m;
    endfunction : apMask

    // Column field in command word is packed contiguously; spread onto pins
    function automatic logic [12:0] colPins(input logic [1:0] w, input logic [9:0] c);
        logic [12:0] a;
        a = 13'h0000;
        case (w)
            ddc_pkg::WID_X32: a = {3'h0, c[8], 1'b0, c[7:0]};
            ddc_pkg::WID_X16: a = {4'h0, c[8:0]};
            default: a = {3'h0, c[9:0]};
        endcase
        return a;
    endfunction : colPins

    assign cmdOp = cur_ff.cmdWord[31:28];
    assign cmdBa = cur_ff.cmdWord[25:24];
    assign cmdAp = cur_ff.cmdWord[23];
    assign cmdArg = cur_ff.cmdWord[12:0];
    assign busy = (cur_ff.cnt != '0);

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.bus.rdValid = 1'b0;
        nxt_cur.bus.waitReq = 1'b1;
        nxt_cur.pins.cmd = ddc_pkg::CMD_NOP;
        nxt_cur.pins.ba = 2'h0;
        nxt_cur.pins.addr = 13'h0000;
        if (cur_ff.cnt != '0) begin
            nxt_cur.cnt = cur_ff.cnt - 1'b1;
        end
        if (cur_ff.guard != '0) begin
            nxt_cur.guard = cur_ff.guard - 1'b1;
        end
        if (cur_ff.rdGuard != '0) begin
            nxt_cur.rdGuard = cur_ff.rdGuard - 1'b1;
        end
        // Bus slave: one-cycle wait, answer on the following edge
        if ((avsRead || avsWrite) && cur_ff.bus.waitReq && !cur_ff.bus.rdValid) begin
            nxt_cur.bus.waitReq = 1'b0;
            nxt_cur.bus.rdValid = 1'b1;
            nxt_cur.bus.rdData = 32'h0000_0000;
            case (avsAddress)
                ddc_pkg::REG_CTRL: nxt_cur.bus.rdData = {30'h0, cur_ff.reqSref, cur_ff.reqPdn};
                ddc_pkg::REG_MODE: nxt_cur.bus.rdData = {19'h0, cur_ff.modeVal};
                ddc_pkg::REG_EMODE: nxt_cur.bus.rdData = {19'h0, cur_ff.emodeVal};
                ddc_pkg::REG_CMD: nxt_cur.bus.rdData = cur_ff.cmdWord;
                ddc_pkg::REG_STAT: nxt_cur.bus.rdData = {16'h0, cur_ff.st, 1'b0,
                    cur_ff.bankOpen[3:0] != 4'h0, cur_ff.cmdPend, cur_ff.done};
                default: nxt_cur.bus.rdData = 32'h0000_0000;
            endcase
        end
        // Write lands at the completing edge, while the master still holds it
        if (avsWrite && !cur_ff.bus.waitReq) begin
            case (avsAddress)
                ddc_pkg::REG_CTRL: begin
                    nxt_cur.reqPdn = avsWriteData[0];
                    nxt_cur.reqSref = avsWriteData[1];
                end
                ddc_pkg::REG_MODE: nxt_cur.modeVal = avsWriteData[12:0];
                ddc_pkg::REG_EMODE: nxt_cur.emodeVal = avsWriteData[12:0];
                ddc_pkg::REG_CMD: begin
                    if (!cur_ff.cmdPend) begin
                        nxt_cur.cmdWord = avsWriteData;
                        nxt_cur.cmdPend = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        case (cur_ff.st)
            ddc_pkg::ST_OFF: begin
                nxt_cur.pins.cke = 1'b0;
                if (vrefStable) begin
                    nxt_cur.st = ddc_pkg::ST_WARM;
                    nxt_cur.cnt = ddc_pkg::CNT_W'(WARM_CYCLES);
                end
            end
            ddc_pkg::ST_WARM: begin
                if (!busy) begin
                    nxt_cur.pins.cke = 1'b1;
                    nxt_cur.st = ddc_pkg::ST_PALL1;
                end
            end
            ddc_pkg::ST_PALL1, ddc_pkg::ST_PALL2: begin
                if (!busy) begin
                    nxt_cur.pins.cmd = ddc_pkg::CMD_PRE;
                    nxt_cur.pins.addr = apMask(WIDTH_SEL);
                    nxt_cur.cnt = ddc_pkg::CNT_W'(ddc_pkg::RP_CYC);
                    nxt_cur.st = (cur_ff.st == ddc_pkg::ST_PALL1) ? ddc_pkg::ST_EMRS
                                                                  : ddc_pkg::ST_AREF;
                    nxt_cur.refs = 2'h0;
                end
            end
            ddc_pkg::ST_EMRS: begin
                if (!busy) begin
                    nxt_cur.pins.cmd = ddc_pkg::CMD_MRS;
                    nxt_cur.pins.ba = ddc_pkg::BA_EMR;
                    nxt_cur.pins.addr = cur_ff.emodeVal;
                    nxt_cur.cnt = ddc_pkg::CNT_W'(ddc_pkg::MRD_CYC);
                    nxt_cur.st = ddc_pkg::ST_MRS1;
                end
            end
            ddc_pkg::ST_MRS1: begin
                if (!busy) begin
                    nxt_cur.pins.cmd = ddc_pkg::CMD_MRS;
                    nxt_cur.pins.ba = ddc_pkg::BA_MR;
                    nxt_cur.pins.addr = cur_ff.modeVal;
                    nxt_cur.pins.addr[ddc_pkg::MR_DLL_BIT] = 1'b1;
                    nxt_cur.cnt = ddc_pkg::CNT_W'(ddc_pkg::MRD_CYC);
                    nxt_cur.guard = ddc_pkg::CNT_W'(ddc_pkg::DLL_CYC);
                    nxt_cur.rdGuard = ddc_pkg::CNT_W'(ddc_pkg::T_XSRD_CYC);
                    nxt_cur.st = ddc_pkg::ST_PALL2;
                end
            end
            ddc_pkg::ST_AREF: begin
                if (!busy) begin
                    nxt_cur.pins.cmd = ddc_pkg::CMD_REF;
                    nxt_cur.cnt = ddc_pkg::CNT_W'(ddc_pkg::RFC_CYC);
                    nxt_cur.refs = cur_ff.refs + 2'h1;
                    if (cur_ff.refs == 2'(ddc_pkg::REF_COUNT - 1)) begin
                        nxt_cur.st = ddc_pkg::ST_MRS2;
                    end
                end
            end
            ddc_pkg::ST_MRS2: begin
                if (!busy) begin
                    nxt_cur.pins.cmd = ddc_pkg::CMD_MRS;
                    nxt_cur.pins.ba = ddc_pkg::BA_MR;
                    nxt_cur.pins.addr = cur_ff.modeVal;
                    nxt_cur.pins.addr[ddc_pkg::MR_DLL_BIT] = 1'b0;
                    nxt_cur.cnt = ddc_pkg::CNT_W'(ddc_pkg::MRD_CYC);
                    nxt_cur.st = ddc_pkg::ST_DLLW;
                end
            end
            ddc_pkg::ST_DLLW: begin
                if (!busy && cur_ff.guard == '0) begin
                    nxt_cur.st = ddc_pkg::ST_READY;
                    nxt_cur.done = 1'b1;
                end
            end
            ddc_pkg::ST_READY: begin
                // Burst and recovery time run in cnt, so cke never drops mid-burst
                if (!busy && cur_ff.reqSref && cur_ff.bankOpen == 4'h0) begin
                    nxt_cur.pins.cmd = ddc_pkg::CMD_REF;
                    nxt_cur.pins.cke = 1'b0;
                    nxt_cur.st = ddc_pkg::ST_SREF;
                end else if (!busy && cur_ff.reqPdn) begin
                    nxt_cur.pins.cke = 1'b0;
                    nxt_cur.st = ddc_pkg::ST_PDN;
                end else if (!busy && cur_ff.cmdPend) begin
                    nxt_cur.cmdPend = 1'b0;
                    nxt_cur.pins.cmd = cmdOp;
                    nxt_cur.pins.ba = cmdBa;
                    case (cmdOp)
                        ddc_pkg::CMD_ACT: begin
                            nxt_cur.pins.addr = (WIDTH_SEL == ddc_pkg::WID_X32)
                                ? {1'b0, cmdArg[11:0]} : cmdArg;
                            nxt_cur.bankOpen[cmdBa] = 1'b1;
                        end
                        ddc_pkg::CMD_RD, ddc_pkg::CMD_WR: begin
                            if (!cur_ff.bankOpen[cmdBa] ||
                                (cmdOp == ddc_pkg::CMD_RD && cur_ff.rdGuard != '0)) begin
                                nxt_cur.pins.cmd = ddc_pkg::CMD_NOP;
                            end else begin
                                nxt_cur.pins.addr = colPins(WIDTH_SEL, cmdArg[9:0])
                                    | (cmdAp ? apMask(WIDTH_SEL) : 13'h0000);
                                // Eight beats fit in four clocks; eight clocks is margin
                                nxt_cur.cnt = ddc_pkg::CNT_W'(8 + ddc_pkg::WR_CYC);
                                if (cmdAp) begin
                                    nxt_cur.bankOpen[cmdBa] = 1'b0;
                                end
                            end
                        end
                        ddc_pkg::CMD_PRE: begin
                            nxt_cur.pins.addr = cmdAp ? apMask(WIDTH_SEL) : 13'h0000;
                            if (cmdAp) begin
                                nxt_cur.bankOpen = 4'h0;
                            end else begin
                                nxt_cur.bankOpen[cmdBa] = 1'b0;
                            end
                            nxt_cur.cnt = ddc_pkg::CNT_W'(ddc_pkg::RP_CYC);
                        end
                        ddc_pkg::CMD_REF: begin
                            nxt_cur.cnt = ddc_pkg::CNT_W'(ddc_pkg::RFC_CYC);
                        end
                        default: nxt_cur.pins.cmd = ddc_pkg::CMD_NOP;
                    endcase
                end
            end
            ddc_pkg::ST_PDN: begin
                if (!cur_ff.reqPdn) begin
                    nxt_cur.pins.cke = 1'b1;
                    nxt_cur.st = ddc_pkg::ST_READY;
                    nxt_cur.cnt = ddc_pkg::CNT_W'(1);
                end
            end
            ddc_pkg::ST_SREF: begin
                if (!cur_ff.reqSref) begin
                    nxt_cur.pins.cke = 1'b1;
                    nxt_cur.st = ddc_pkg::ST_READY;
                    nxt_cur.cnt = ddc_pkg::CNT_W'(ddc_pkg::SNR_CYC);
                end
            end
            default: nxt_cur.st = ddc_pkg::ST_OFF;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cur_ff <= '0;
            cur_ff.st <= ddc_pkg::ST_OFF;
            cur_ff.pins.cmd <= ddc_pkg::CMD_NOP;
            cur_ff.bus.waitReq <= 1'b1;
            cur_ff.modeVal <= ddc_pkg::RST_MODE[12:0];
            cur_ff.emodeVal <= ddc_pkg::RST_EMODE[12:0];
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign avsReadData = cur_ff.bus.rdData;
    assign avsWaitRequest = cur_ff.bus.waitReq;
    assign dramCke = cur_ff.pins.cke;
    assign {dramCsN, dramRasN, dramCasN, dramWeN} = cur_ff.pins.cmd;
    assign dramBa = cur_ff.pins.ba;
    assign dramAddr = cur_ff.pins.addr;
    assign initDone = cur_ff.done;

    property p_ckeLowOff;
        @(posedge mclk) disable iff (sys_rst)
        (cur_ff.st == ddc_pkg::ST_OFF) |=> !dramCke;
    endproperty
    a_ckeLowOff: assert property (p_ckeLowOff) else $error("cke high before vref");

    property p_warmNop;
        @(posedge mclk) disable iff (sys_rst)
        (cur_ff.st == ddc_pkg::ST_WARM) |-> (cur_ff.pins.cmd == ddc_pkg::CMD_NOP);
    endproperty
    a_warmNop: assert property (p_warmNop) else $error("command during warm-up");

    property p_dllBit;
        @(posedge mclk) disable iff (sys_rst)
        $rose(cur_ff.st == ddc_pkg::ST_DLLW) |-> (dramCsN == 1'b0) && !dramAddr[8] && dramBa == 2'h0;
    endproperty
    a_dllBit: assert property (p_dllBit) else $error("final MRS has DLL reset");

    property p_emrsBa;
        @(posedge mclk) disable iff (sys_rst)
        $rose(cur_ff.st == ddc_pkg::ST_MRS1) |-> dramBa == ddc_pkg::BA_EMR;
    endproperty
    a_emrsBa: assert property (p_emrsBa) else $error("EMRS bank select wrong");

    property p_doneDll;
        @(posedge mclk) disable iff (sys_rst)
        $rose(initDone) |-> cur_ff.guard == '0;
    endproperty
    a_doneDll: assert property (p_doneDll) else $error("ready before DLL wait");

    property p_ckeBurst;
        @(posedge mclk) disable iff (sys_rst)
        (cur_ff.st == ddc_pkg::ST_READY && busy) |=> dramCke;
    endproperty
    a_ckeBurst: assert property (p_ckeBurst) else $error("cke dropped while busy");

    property p_ckeFallNop;
        @(posedge mclk) disable iff (sys_rst)
        $fell(dramCke) && initDone |-> (cur_ff.pins.cmd == ddc_pkg::CMD_NOP
                                       || cur_ff.pins.cmd == ddc_pkg::CMD_REF);
    endproperty
    a_ckeFallNop: assert property (p_ckeFallNop) else $error("illegal cke fall");

    property p_srefExit;
        @(posedge mclk) disable iff (sys_rst)
        $rose(dramCke) && $past(cur_ff.st) == ddc_pkg::ST_SREF
        |-> (dramCsN || cur_ff.pins.cmd == ddc_pkg::CMD_NOP) [*4];
    endproperty
    a_srefExit: assert property (p_srefExit) else $error("command inside tSNR");
endmodule : ddc_ctrl

// ===== tb/ddc_dram_model.sv
`timescale 1ns/1ps
module ddc_dram_model #(
    parameter int WARM = 20
) (
    input wire logic mclk,
    input wire ddc_pkg::ddc_pins_s pins,
    output logic [12:0] modeReg,
    output logic [12:0] emodeReg,
    output logic [3:0] openMask,
    output logic [1:0] pwrState,
    output logic [12:0] lastRow,
    output logic [12:0] lastCol,
    output logic [7:0] refCount,
    output logic [7:0] dllResets,
    output logic [7:0] violations
);
    logic ckePrev;
    logic nopCmd;
    int gap, need, sinceDll, holdCke, clocks, bad;
    // Chip select high is a deselect, whatever the rest says
    assign nopCmd = pins.cmd[3] || (pins.cmd == ddc_pkg::CMD_NOP);
    initial begin
        // No reset value: left unknown until programmed
        {modeReg, emodeReg} = 'x;
        {ckePrev, openMask, pwrState, lastRow, lastCol, refCount, dllResets, violations} = '0;
        {gap, need, holdCke, clocks} = '0;
        sinceDll = 100000;
    end
    always @(posedge mclk) begin
        bad = 0;
        clocks <= clocks + 1;
        gap <= gap + 1;
        sinceDll <= sinceDll + 1;
        if (holdCke > 0) holdCke <= holdCke - 1;
        ckePrev <= pins.cke;
        if (ckePrev && pins.cke && !nopCmd) begin
            gap <= 1;
            need <= 0;
            if (gap < need || clocks < WARM) bad++;
            case (pins.cmd)
                ddc_pkg::CMD_ACT: begin
                    if (sinceDll < ddc_pkg::DLL_CYC || $isunknown({modeReg, emodeReg})) bad++;
                    openMask[pins.ba] <= 1'b1;
                    lastRow <= pins.addr;
                end
                ddc_pkg::CMD_RD, ddc_pkg::CMD_WR: begin
                    if (!openMask[pins.ba]) bad++;
                    if (pins.cmd == ddc_pkg::CMD_RD && sinceDll < ddc_pkg::T_XSRD_CYC) bad++;
                    lastCol <= pins.addr;
                    // Burst of eight takes four clocks, then write recovery
                    holdCke <= 4 + ddc_pkg::WR_CYC;
                    if (pins.addr[10]) openMask[pins.ba] <= 1'b0;
                end
                ddc_pkg::CMD_PRE: begin
                    if (pins.addr[10]) openMask <= 4'h0;
                    else openMask[pins.ba] <= 1'b0;
                    need <= ddc_pkg::RP_CYC;
                end
                ddc_pkg::CMD_REF: begin
                    if (openMask != 4'h0) bad++;
                    refCount <= refCount + 8'h01;
                    need <= ddc_pkg::RFC_CYC;
                end
                ddc_pkg::CMD_MRS: begin
                    need <= ddc_pkg::MRD_CYC;
                    if (pins.ba == ddc_pkg::BA_EMR) emodeReg <= pins.addr;
                    else if (pins.ba == ddc_pkg::BA_MR) begin
                        modeReg <= pins.addr;
                        if (pins.addr[ddc_pkg::MR_DLL_BIT]) begin
                            dllResets <= dllResets + 8'h01;
                            sinceDll <= 0;
                        end
                    end
                end
                default: ;
            endcase
        end else if (ckePrev && !pins.cke) begin
            if (holdCke > 0) bad++;
            if (pins.cmd == ddc_pkg::CMD_REF && openMask == 4'h0) pwrState <= 2'h3;
            else if (nopCmd) pwrState <= (openMask != 4'h0) ? 2'h2 : 2'h1;
            else bad++;
        end else if (!ckePrev && pins.cke) begin
            if (!nopCmd) bad++;
            if (pwrState == 2'h3) begin
                gap <= 1;
                need <= ddc_pkg::SNR_CYC;
            end
            pwrState <= 2'h0;
        end
        violations <= violations + 8'(bad);
    end
endmodule : ddc_dram_model

// ===== tb/testbench.sv
`timescale 1ns/1ps
`define CHK(got, exp) check(32'(got), 32'(exp));
module testbench;
    logic mclk = 1'b0;
    logic sysRst = 1'b1;
    logic [3:0] avsAddress = 4'h0;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h0;
    logic vrefStable = 1'b0;
    logic [31:0] avsReadData, rdVal;
    logic avsWaitRequest, initDone;
    wire ddc_pkg::ddc_pins_s pins;
    logic [12:0] modeReg, emodeReg, lastRow, lastCol;
    logic [3:0] openMask;
    logic [1:0] pwrState;
    logic [7:0] refCount, dllResets, violations;
    int errTotal = 0;
    int testsRun = 0;
    initial begin
        forever #10 mclk = ~mclk;
    end
    ddc_ctrl #(.WARM_CYCLES(20), .WIDTH_SEL(ddc_pkg::WID_X16)) ddc_ctrl_inst (
        .mclk(mclk), .sys_rst(sysRst), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .vrefStable(vrefStable), .dramCke(pins.cke),
        .dramCsN(pins.cmd[3]), .dramRasN(pins.cmd[2]), .dramCasN(pins.cmd[1]),
        .dramWeN(pins.cmd[0]), .dramBa(pins.ba), .dramAddr(pins.addr), .initDone(initDone));
    ddc_dram_model #(.WARM(20)) ddc_dram_model_inst (
        .mclk(mclk), .pins(pins), .modeReg(modeReg), .emodeReg(emodeReg),
        .openMask(openMask), .pwrState(pwrState), .lastRow(lastRow), .lastCol(lastCol),
        .refCount(refCount), .dllResets(dllResets), .violations(violations));
    task automatic stopTest;
        if (errTotal == 0 && testsRun > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stopTest
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            errTotal++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Starts one edge late so back-to-back calls never drive a strobe twice at once
    task automatic busXfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        avsAddress <= a;
        avsWriteData <= d;
        avsRead <= !wr;
        avsWrite <= wr;
        do begin
            @(posedge mclk);
            n++;
        end while (avsWaitRequest !== 1'b0 && n < 50);
        rdVal = avsReadData;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        if (n >= 50) begin
            errTotal++;
            stopTest();
        end
    endtask : busXfer
    task automatic doCmd(input logic [3:0] op, input logic [1:0] bank, input logic ap,
            input logic [12:0] a);
        int n;
        n = 0;
        busXfer(1'b1, ddc_pkg::REG_CMD, {op, 2'h0, bank, ap, 10'h0, a});
        do begin
            busXfer(1'b0, ddc_pkg::REG_STAT, 32'h0);
            n++;
        end while (rdVal[1] !== 1'b0 && n < 100);
        if (n >= 100) begin
            errTotal++;
            stopTest();
        end
    endtask : doCmd
    task automatic waitPwr(input logic [1:0] exp);
        int n;
        n = 0;
        while (pwrState !== exp && n < 200) begin
            @(posedge mclk);
            n++;
        end
        `CHK(pwrState, exp)
    endtask : waitPwr
    initial begin
        int n;
        repeat (5) @(posedge mclk);
        sysRst <= 1'b0;
        busXfer(1'b0, ddc_pkg::REG_MODE, 32'h0);
        `CHK(rdVal, ddc_pkg::RST_MODE)
        busXfer(1'b1, 4'h7, 32'h1234_5678);
        busXfer(1'b0, 4'h7, 32'h0);
        `CHK(rdVal, 32'h0)
        busXfer(1'b1, ddc_pkg::REG_MODE, 32'h0000_0033);
        busXfer(1'b1, ddc_pkg::REG_EMODE, 32'h0000_0002);
        repeat (30) @(posedge mclk);
        `CHK(pins.cke, 1'b0)
        vrefStable <= 1'b1;
        n = 0;
        while (initDone !== 1'b1 && n < 3000) begin
            @(posedge mclk);
            n++;
        end
        `CHK(initDone, 1'b1)
        `CHK(modeReg, 13'h0033)
        `CHK(emodeReg, 13'h0002)
        `CHK(dllResets, 8'h01)
        `CHK(refCount >= 8'h02, 1'b1)
        `CHK(violations, 8'h00)
        doCmd(ddc_pkg::CMD_ACT, 2'h2, 1'b0, 13'h1ABC);
        `CHK(lastRow, 13'h1ABC)
        `CHK(openMask, 4'h4)
        doCmd(ddc_pkg::CMD_WR, 2'h2, 1'b1, 13'h0155);
        `CHK(lastCol, 13'h0555)
        `CHK(openMask, 4'h0)
        doCmd(ddc_pkg::CMD_ACT, 2'h1, 1'b0, 13'h00F0);
        doCmd(ddc_pkg::CMD_RD, 2'h1, 1'b0, 13'h01AA);
        `CHK(lastCol, 13'h01AA)
        busXfer(1'b1, ddc_pkg::REG_CTRL, 32'h1);
        waitPwr(2'h2);
        `CHK(openMask, 4'h2)
        busXfer(1'b1, ddc_pkg::REG_CTRL, 32'h0);
        waitPwr(2'h0);
        `CHK(openMask, 4'h2)
        doCmd(ddc_pkg::CMD_PRE, 2'h0, 1'b1, 13'h0);
        `CHK(openMask, 4'h0)
        busXfer(1'b1, ddc_pkg::REG_CTRL, 32'h1);
        waitPwr(2'h1);
        busXfer(1'b1, ddc_pkg::REG_CTRL, 32'h2);
        waitPwr(2'h0);
        waitPwr(2'h3);
        busXfer(1'b1, ddc_pkg::REG_CTRL, 32'h0);
        waitPwr(2'h0);
        doCmd(ddc_pkg::CMD_ACT, 2'h3, 1'b0, 13'h1FFF);
        `CHK(lastRow, 13'h1FFF)
        `CHK(violations, 8'h00)
        stopTest();
    end
endmodule : testbench
